// [rtl/bssp_port.v]
`timescale 1ns/1ps
`include "bssp_defines.vh"
// Operation
// - Transmit mode shifts RAM bytes out on falling
// - Receive mode samples rising edge, stores bytes
// - Internal clock drives 50% duty shift clock
// - Send programmed byte count with gaps between
// - Select enable lets select pin govern transfers
// - Early select rise aborts transfer at once
// - Select high floats shift clock and output
// - External clock shifts per edge; gap may be none
// - Completion sets done flag and interrupt
// - Select abort sets abort flag and interrupt
// - Run bit one starts, zero stops
// - Select mode waits for select falling edge
// - Run bit clears itself when transfer ends
// - Gap 16, 32, 64 periods or none
// - Byte count plus one; split mode 64
// - Interrupt forwarded only when enabled
// - Flag clears on zero; clear reads one
module bssp_port (
	input wire I_CLK,
	input wire I_RST_B,
	input wire I_RUN_WR,
	input wire I_RUN_DATA,
	input wire I_DIR_TX_ONLY,
	input wire I_SELECT_AUTO_ENABLE,
	input wire I_IRQ_ENABLE_BIT,
	input wire I_DONE_FLAG_CLEAR_N,
	input wire I_ABORT_FLAG_CLEAR_N,
	input wire [2:0] I_SHIFT_CLK_SEL,
	input wire I_GAP_SEL_HI,
	input wire I_GAP_SEL_LO,
	input wire I_BUFFER_SPLIT_MODE,
	input wire [6:0] I_BYTE_COUNT_FIELD,
	input wire [6:0] I_ADDR_OFFSET,
	input wire [7:0] I_RAM_RDATA,
	input wire I_RAM_WREADY,
	input wire I_SCK_IN,
	input wire I_SDI,
	input wire I_SELECT_IN_N,
	output reg [6:0] O_RAM_RADDR,
	output reg O_RAM_WE,
	output reg [6:0] O_RAM_WADDR,
	output reg [7:0] O_RAM_WDATA,
	output reg O_SCK_OUT,
	output reg O_SCK_OE,
	output reg O_SDO,
	output reg O_SDO_OE,
	output reg O_XFER_RUN_BIT,
	output reg O_XFER_DONE_FLAG,
	output reg O_SELECT_ABORT_FLAG,
	output reg O_FLAG_CLEAR_READ,
	output reg O_IRQ
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	reg sck_m;
	reg sck_s;
	reg sck_d;
	reg sdi_m;
	reg sdi_s;
	reg sel_m;
	reg sel_s;
	reg sel_d;
	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sck_m <= 1'b1;
			sck_s <= 1'b1;
			sck_d <= 1'b1;
			sdi_m <= 1'b0;
			sdi_s <= 1'b0;
			sel_m <= 1'b1;
			sel_s <= 1'b1;
			sel_d <= 1'b1;
		end else begin
			sck_m <= I_SCK_IN;
			sck_s <= sck_m;
			sck_d <= sck_s;
			sdi_m <= I_SDI;
			sdi_s <= sdi_m;
			sel_m <= I_SELECT_IN_N;
			sel_s <= sel_m;
			sel_d <= sel_s;
		end
	end
	wire ext_mode;
	wire ext_fall;
	wire ext_rise;
	wire sel_fall;
	wire sel_rise;
	assign ext_mode = (I_SHIFT_CLK_SEL == `BSSP_SC_EXT);
	assign ext_fall = sck_d & ~sck_s;
	assign ext_rise = ~sck_d & sck_s;
	assign sel_fall = sel_d & ~sel_s;
	assign sel_rise = ~sel_d & sel_s;

	// ****************************************
	// Configuration decode
	// ****************************************
	reg [5:0] half_len;
	reg [6:0] gap_len;
	wire [1:0] gap_code;
	wire [6:0] last_idx;
	assign gap_code = {I_GAP_SEL_HI, I_GAP_SEL_LO};
	assign last_idx = I_BUFFER_SPLIT_MODE ? (I_BYTE_COUNT_FIELD & `BSSP_SPLIT_MASK) : I_BYTE_COUNT_FIELD;
	always @* begin
		case (I_SHIFT_CLK_SEL)
			`BSSP_SC_INT8: half_len = `BSSP_HALF8;
			`BSSP_SC_INT16: half_len = `BSSP_HALF16;
			`BSSP_SC_INT32: half_len = `BSSP_HALF32;
			default: half_len = `BSSP_HALF8;
		endcase
		case (gap_code)
			`BSSP_GAP16: gap_len = `BSSP_GAP_LEN16;
			`BSSP_GAP32: gap_len = `BSSP_GAP_LEN32;
			`BSSP_GAP64: gap_len = `BSSP_GAP_LEN64;
			default: gap_len = 7'h00;
		endcase
	end

	// ****************************************
	// Transmit fetch path through the FIFO
	// ****************************************
	reg [6:0] fetch_idx;
	reg fetch_wait;
	reg fetch_pend;
	reg fetch_done;
	wire [6:0] rd_addr;
	// Offset plus index wraps inside the 128 byte buffer
	assign rd_addr = I_ADDR_OFFSET + fetch_idx;
	wire fifo_in_ready;
	wire [7:0] fifo_data;
	wire fifo_valid;
	reg fifo_pop;
	reg flush;
	bssp_fifo #(
		.WIDTH(8),
		.DEPTH(`BSSP_FIFO_DEPTH),
		.AW(`BSSP_FIFO_AW)
	) u_fifo (
		.clk(I_CLK),
		.rst_b(I_RST_B),
		.flush(flush),
		.in_data(I_RAM_RDATA),
		.in_valid(fetch_pend),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);
	// Read data stands one cycle after the address edge, so a fetch waits
	// one cycle before its byte is offered to the FIFO. Only one fetch is
	// in flight, so a full FIFO never drops a byte that is on its way.
	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			fetch_idx <= 7'h00;
			fetch_wait <= 1'b0;
			fetch_pend <= 1'b0;
			fetch_done <= 1'b0;
			O_RAM_RADDR <= 7'h00;
		end else if (flush) begin
			fetch_idx <= 7'h00;
			fetch_wait <= 1'b0;
			fetch_pend <= 1'b0;
			fetch_done <= 1'b0;
		end else if (O_XFER_RUN_BIT) begin
			fetch_wait <= 1'b0;
			// Byte now stands on the read data
			if (fetch_wait)
				fetch_pend <= 1'b1;
			else if (fetch_pend && fifo_in_ready)
				fetch_pend <= 1'b0;
			// Next address only once the last byte is in the FIFO
			if (!fetch_done && !fetch_wait && !fetch_pend) begin
				O_RAM_RADDR <= rd_addr;
				fetch_wait <= 1'b1;
				fetch_idx <= fetch_idx + 7'h01;
				if (fetch_idx == last_idx)
					fetch_done <= 1'b1;
			end
		end
	end

	// ****************************************
	// Shift engine
	// ****************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_WSEL = 3'h1;
	localparam ST_LOAD = 3'h2;
	localparam ST_LOW = 3'h3;
	localparam ST_HIGH = 3'h4;
	localparam ST_GAP = 3'h5;
	reg [2:0] state;
	reg [7:0] shreg;
	reg [2:0] bit_cnt;
	reg [6:0] byte_cnt;
	reg [5:0] half_cnt;
	reg [6:0] gap_cnt;
	reg gap_ph;
	wire [6:0] rx_base;
	wire [6:0] wr_addr;
	wire shift_fall;
	wire shift_rise;
	wire half_end;
	wire last_byte;
	assign half_end = (half_cnt == half_len - 6'h01);
	assign last_byte = (byte_cnt == last_idx);

	// ****************************************
	// Receive address
	// ****************************************
	// Split mode moves received bytes up by half the buffer (64 bytes)
	assign rx_base = I_BUFFER_SPLIT_MODE ? `BSSP_RX_BASE : 7'h00;
	// Sum wraps inside the 128 byte buffer
	assign wr_addr = I_ADDR_OFFSET + byte_cnt + rx_base;
	assign shift_fall = ext_mode ? ext_fall : (state == ST_HIGH && half_end);
	assign shift_rise = ext_mode ? ext_rise : (state == ST_LOW && half_end);

	always @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state <= ST_IDLE;
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 7'h00;
			half_cnt <= 6'h00;
			gap_cnt <= 7'h00;
			gap_ph <= 1'b0;
			fifo_pop <= 1'b0;
			flush <= 1'b0;
			O_XFER_RUN_BIT <= 1'b0;
			O_XFER_DONE_FLAG <= 1'b0;
			O_SELECT_ABORT_FLAG <= 1'b0;
			O_FLAG_CLEAR_READ <= 1'b1;
			O_SCK_OUT <= 1'b1;
			O_SCK_OE <= 1'b0;
			O_SDO <= 1'b1;
			O_SDO_OE <= 1'b0;
			O_RAM_WE <= 1'b0;
			O_RAM_WADDR <= 7'h00;
			O_RAM_WDATA <= 8'h00;
			O_IRQ <= 1'b0;
		end else begin
			fifo_pop <= 1'b0;
			flush <= 1'b0;
			O_FLAG_CLEAR_READ <= 1'b1;
			if (O_RAM_WE && I_RAM_WREADY)
				O_RAM_WE <= 1'b0;
			// Flag clears; a same-cycle set below wins
			if (!I_DONE_FLAG_CLEAR_N)
				O_XFER_DONE_FLAG <= 1'b0;
			if (!I_ABORT_FLAG_CLEAR_N)
				O_SELECT_ABORT_FLAG <= 1'b0;
			O_IRQ <= I_IRQ_ENABLE_BIT & (O_XFER_DONE_FLAG | O_SELECT_ABORT_FLAG);
			// Pins float while select is high in select mode
			O_SCK_OE <= ~ext_mode & ~(I_SELECT_AUTO_ENABLE & sel_s);
			O_SDO_OE <= ~(I_SELECT_AUTO_ENABLE & sel_s);
			if (I_RUN_WR && !I_RUN_DATA) begin
				O_XFER_RUN_BIT <= 1'b0;
				state <= ST_IDLE;
				O_SCK_OUT <= 1'b1;
				flush <= 1'b1;
			end else if (I_SELECT_AUTO_ENABLE && sel_rise && state != ST_IDLE && state != ST_WSEL) begin
				O_XFER_RUN_BIT <= 1'b0;
				O_SELECT_ABORT_FLAG <= 1'b1;
				state <= ST_IDLE;
				O_SCK_OUT <= 1'b1;
				flush <= 1'b1;
			end else begin
				case (state)
					ST_IDLE: begin
						O_SCK_OUT <= 1'b1;
						if (I_RUN_WR && I_RUN_DATA) begin
							O_XFER_RUN_BIT <= 1'b1;
							byte_cnt <= 7'h00;
							state <= I_SELECT_AUTO_ENABLE ? ST_WSEL : ST_LOAD;
						end
					end
					ST_WSEL: begin
						if (sel_fall)
							state <= ST_LOAD;
					end
					ST_LOAD: begin
						if (fifo_valid) begin
							shreg <= fifo_data;
							fifo_pop <= 1'b1;
							bit_cnt <= 3'h0;
							half_cnt <= 6'h00;
							state <= ST_HIGH;
						end
					end
					ST_HIGH: begin
						if (!ext_mode)
							half_cnt <= half_end ? 6'h00 : half_cnt + 6'h01;
						if (shift_fall) begin
							O_SDO <= shreg[7];
							O_SCK_OUT <= 1'b0;
							state <= ST_LOW;
						end
					end
					ST_LOW: begin
						if (!ext_mode)
							half_cnt <= half_end ? 6'h00 : half_cnt + 6'h01;
						if (shift_rise) begin
							O_SCK_OUT <= 1'b1;
							shreg <= {shreg[6:0], sdi_s};
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == 3'h7) begin
								if (!I_DIR_TX_ONLY) begin
									O_RAM_WE <= 1'b1;
									O_RAM_WDATA <= {shreg[6:0], sdi_s};
									O_RAM_WADDR <= wr_addr;
								end
								if (last_byte) begin
									O_XFER_RUN_BIT <= 1'b0;
									O_XFER_DONE_FLAG <= 1'b1;
									state <= ST_IDLE;
									flush <= 1'b1;
								end else begin
									byte_cnt <= byte_cnt + 7'h01;
									gap_cnt <= 7'h00;
									gap_ph <= 1'b0;
									state <= (gap_len == 7'h00) ? ST_LOAD : ST_GAP;
								end
							end else
								state <= ST_HIGH;
						end
					end
					ST_GAP: begin
						// Gap counted in shift clock periods: two half periods
						// internally, one falling edge of the external clock
						if (half_end)
							gap_ph <= ~gap_ph;
						if (ext_mode ? ext_fall : (half_end && gap_ph)) begin
							gap_cnt <= gap_cnt + 7'h01;
							if (gap_cnt == gap_len - 7'h01)
								state <= ST_LOAD;
						end
						half_cnt <= half_end ? 6'h00 : half_cnt + 6'h01;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // bssp_port

// [rtl/bssp_defines.vh]
`ifndef BSSP_DEFINES_VH
`define BSSP_DEFINES_VH

// Shift clock selector codes
`define BSSP_SC_INT8 3'h1
`define BSSP_SC_INT16 3'h2
`define BSSP_SC_INT32 3'h3
`define BSSP_SC_EXT 3'h5
// Half periods of the internal shift clock, in system clocks
`define BSSP_HALF8 6'h04
`define BSSP_HALF16 6'h08
`define BSSP_HALF32 6'h10
// Gap selector codes and gap lengths in shift clock periods
`define BSSP_GAP16 2'h0
`define BSSP_GAP32 2'h1
`define BSSP_GAP64 2'h2
`define BSSP_GAP_NONE 2'h3
`define BSSP_GAP_LEN16 7'h10
`define BSSP_GAP_LEN32 7'h20
`define BSSP_GAP_LEN64 7'h40
// Receive area offset in split buffer mode
`define BSSP_RX_BASE 7'h40
`define BSSP_SPLIT_MASK 7'h3F
// FIFO geometry
`define BSSP_FIFO_DEPTH 8
`define BSSP_FIFO_AW 3

`endif

// [rtl/bssp_fifo.v]
`timescale 1ns/1ps
// ****************************************
// Synchronous FIFO with valid/ready
// ****************************************
module bssp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst_b,
	input wire flush,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wp;
	reg [AW:0] rp;
	wire empty;
	wire full;
	wire do_wr;
	wire do_rd;
	assign empty = (wp == rp);
	assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	assign in_ready = ~full;
	assign do_wr = in_valid & ~full;
	assign do_rd = ~empty & (~out_valid | out_ready);
	always @(posedge clk) begin
		if (do_wr)
			mem[wp[AW-1:0]] <= in_data;
	end
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp <= {(AW+1){1'b0}};
			rp <= {(AW+1){1'b0}};
			out_data <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
		end else if (flush) begin
			wp <= {(AW+1){1'b0}};
			rp <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
		end else begin
			if (do_wr)
				wp <= wp + 1'b1;
			if (do_rd) begin
				out_data <= mem[rp[AW-1:0]];
				out_valid <= 1'b1;
				rp <= rp + 1'b1;
			end else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule // bssp_fifo

// [sim/bssp_port_chk.sv]
`timescale 1ns/1ps
module bssp_port_chk (
	input wire I_CLK,
	input wire I_RST_B,
	input wire I_RUN_WR,
	input wire I_RUN_DATA,
	input wire I_SELECT_AUTO_ENABLE,
	input wire I_SELECT_IN_N,
	input wire I_IRQ_ENABLE_BIT,
	input wire I_DONE_FLAG_CLEAR_N,
	input wire [2:0] I_SHIFT_CLK_SEL,
	input wire O_SCK_OUT,
	input wire O_SCK_OE,
	input wire O_SDO,
	input wire O_SDO_OE,
	input wire O_XFER_RUN_BIT,
	input wire O_XFER_DONE_FLAG,
	input wire O_SELECT_ABORT_FLAG,
	input wire O_FLAG_CLEAR_READ,
	input wire O_IRQ
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	property p_start;
		I_RUN_WR && I_RUN_DATA && !I_SELECT_AUTO_ENABLE |=> O_XFER_RUN_BIT;
	endproperty
	a_start: assert property (p_start) else $error("run bit not set");
	property p_stop;
		I_RUN_WR && !I_RUN_DATA |=> !O_XFER_RUN_BIT;
	endproperty
	a_stop: assert property (p_stop) else $error("run bit not cleared");
	property p_irq;
		O_IRQ == $past(I_IRQ_ENABLE_BIT && (O_XFER_DONE_FLAG || O_SELECT_ABORT_FLAG));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	property p_done;
		$rose(O_XFER_DONE_FLAG) |-> !O_XFER_RUN_BIT;
	endproperty
	a_done: assert property (p_done) else $error("done while running");
	property p_rd1;
		O_FLAG_CLEAR_READ;
	endproperty
	a_rd1: assert property (p_rd1) else $error("clear bit reads 0");
	property p_clr;
		O_XFER_DONE_FLAG && !I_DONE_FLAG_CLEAR_N && !O_XFER_RUN_BIT |=> !O_XFER_DONE_FLAG;
	endproperty
	a_clr: assert property (p_clr) else $error("done flag kept");
	property p_float;
		(I_SELECT_AUTO_ENABLE && I_SELECT_IN_N) [*4] |=> !O_SCK_OE && !O_SDO_OE;
	endproperty
	a_float: assert property (p_float) else $error("pins driven");
	property p_ext;
		I_SHIFT_CLK_SEL == 3'h5 && $past(I_SHIFT_CLK_SEL) == 3'h5 |-> !O_SCK_OE;
	endproperty
	a_ext: assert property (p_ext) else $error("clock driven in ext mode");
	property p_idle;
		(I_SHIFT_CLK_SEL != 3'h5 && !O_XFER_RUN_BIT) [*3] |-> O_SCK_OUT;
	endproperty
	a_idle: assert property (p_idle) else $error("clock idle low");
	property p_sdo;
		$changed(O_SDO) && O_XFER_RUN_BIT && !O_SCK_OUT |-> $fell(O_SCK_OUT);
	endproperty
	a_sdo: assert property (p_sdo) else $error("data moved off fall");
	property p_half;
		I_SHIFT_CLK_SEL == 3'h1 && O_XFER_RUN_BIT && $fell(O_SCK_OUT) |-> !O_SCK_OUT [*4] ##1 O_SCK_OUT;
	endproperty
	a_half: assert property (p_half) else $error("duty wrong");
	c_done: cover property ($rose(O_XFER_DONE_FLAG));
	c_abort: cover property ($rose(O_SELECT_ABORT_FLAG));
	c_irq: cover property ($rose(O_IRQ));
endmodule // bssp_port_chk
bind bssp_port bssp_port_chk i_chk (.*);

// [sim/bssp_peer.sv]
`timescale 1ns/1ps
module bssp_peer (
	input wire ext_en,
	input wire sdo,
	output reg sck,
	output wire sdi
);
	// Inverted echo, so received data differs from sent data
	assign sdi = ~sdo;
	initial sck = 1'b1;
	// Clock runs only within frames
	always #40 sck = ext_en ? ~sck : 1'b1;
endmodule // bssp_peer

// [sim/testbench.sv]
`timescale 1ns/1ps
`define CHK(n,e,a) begin checks=checks+1; if((a)!==(e)) begin n_fail=n_fail+1; $display("[FAIL] %s exp %0h got %0h",n,e,a); end end
module testbench;
	reg clk, rst_b, wr, wd, tx, se, ie, dcn, acn, ghi, glo, sp, csn, pq;
	reg [2:0] cs;
	reg [6:0] cnt, off;
	reg [7:0] ram [0:127];
	reg [7:0] rd, sh;
	reg [40:0] rows [0:4];
	wire [6:0] ra, wa;
	wire [7:0] wdt;
	wire we, so, soe, sdo, doe, run, done, ab, crd, irq, ps, sdi;
	wire sck = soe ? so : ps;
	integer n_fail, checks, i, nf, nw, nb, hi, mhi, k;
	bssp_port i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_RUN_WR(wr), .I_RUN_DATA(wd), .I_DIR_TX_ONLY(tx),
		.I_SELECT_AUTO_ENABLE(se), .I_IRQ_ENABLE_BIT(ie), .I_DONE_FLAG_CLEAR_N(dcn), .I_ABORT_FLAG_CLEAR_N(acn),
		.I_SHIFT_CLK_SEL(cs), .I_GAP_SEL_HI(ghi), .I_GAP_SEL_LO(glo), .I_BUFFER_SPLIT_MODE(sp),
		.I_BYTE_COUNT_FIELD(cnt), .I_ADDR_OFFSET(off), .I_RAM_RDATA(rd), .I_RAM_WREADY(1'b1), .I_SCK_IN(sck),
		.I_SDI(sdi), .I_SELECT_IN_N(csn), .O_RAM_RADDR(ra), .O_RAM_WE(we), .O_RAM_WADDR(wa), .O_RAM_WDATA(wdt),
		.O_SCK_OUT(so), .O_SCK_OE(soe), .O_SDO(sdo), .O_SDO_OE(doe), .O_XFER_RUN_BIT(run),
		.O_XFER_DONE_FLAG(done), .O_SELECT_ABORT_FLAG(ab), .O_FLAG_CLEAR_READ(crd), .O_IRQ(irq));
	bssp_peer i_peer (.ext_en(cs == 3'h5 && run), .sdo(sdo), .sck(ps), .sdi(sdi));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		rd <= ram[ra];
		pq <= sck;
		if (run && pq && !sck) nf = nf + 1;
		if (run && soe && sck) begin
			hi = hi + 1;
			if (hi > mhi) mhi = hi;
		end else hi = 0;
		if (tx && soe && sck && !pq) begin
			sh = {sh[6:0], sdo};
			nb = nb + 1;
			if (nb % 8 == 0) `CHK("sdo", ram[7'(off + nb / 8 - 1)], sh)
		end
		if (we) begin
			`CHK("rx", ~ram[wa - {sp, 6'h00}], wdt)
			ram[wa] = wdt;
			nw = nw + 1;
		end
	end
	task give_verdict;
		begin
			if (n_fail == 0 && checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task pulse(input v);
		begin
			@(negedge clk) wr = 1;
			wd = v;
			@(negedge clk) wr = 0;
		end
	endtask
	task go(input [40:0] r);
		begin
			{tx, cs, ghi, glo, sp, cnt, off} = r[40:20];
			nf = 0;
			nw = 0;
			nb = 0;
			mhi = 0;
			k = 0;
			pulse(1);
			repeat (3) @(negedge clk);
			while (run && k < 20000) begin
				@(negedge clk);
				k = k + 1;
			end
			@(negedge clk);
			if (cs != 3'h5) `CHK("falls", {r[19:12], 3'h0}, nf)
			`CHK("writes", tx ? 0 : r[19:12], nw)
			`CHK("end", 3'b110, {done, irq, run})
			if (r[11:0]) `CHK("gap", 1'b1, mhi >= r[11:0] && mhi < r[11:0] + 40)
			@(negedge clk) dcn = 0;
			@(negedge clk) dcn = 1;
			@(negedge clk) `CHK("clr", 2'b00, {done, irq})
		end
	endtask
	initial begin
		rst_b = 0; wr = 0; wd = 1; tx = 0; se = 0; ie = 1; dcn = 1; acn = 1; ghi = 0; glo = 0; sp = 0;
		csn = 1; cs = 3'h1; cnt = 0; off = 0; n_fail = 0; checks = 0; pq = 1; hi = 0; nf = 0; nw = 0; nb = 0;
		for (i = 0; i < 128; i = i + 1) ram[i] = i * 37 + 5;
		rows[0] = {1'b0, 3'h1, 2'h0, 1'b0, 7'h02, 7'h10, 8'h03, 12'h080};
		rows[1] = {1'b1, 3'h2, 2'h1, 1'b0, 7'h01, 7'h7F, 8'h02, 12'h200};
		rows[2] = {1'b0, 3'h1, 2'h2, 1'b1, 7'h41, 7'h05, 8'h02, 12'h200};
		rows[3] = {1'b0, 3'h5, 2'h0, 1'b0, 7'h01, 7'h20, 8'h02, 12'h000};
		rows[4] = {1'b1, 3'h1, 2'h3, 1'b0, 7'h7F, 7'h00, 8'h80, 12'h000};
		repeat (8) @(negedge clk);
		`CHK("rst", 4'b1100, {so, crd, run, done})
		rst_b = 1;
		repeat (2) @(negedge clk);
		for (i = 0; i < 5; i = i + 1) go(rows[i]);
		{ie, se, tx, cs, ghi, glo, sp, cnt} = {3'b010, 3'h2, 2'h0, 1'b0, 7'h7F};
		nf = 0;
		pulse(1);
		repeat (40) @(negedge clk);
		`CHK("hold", 3'b100, {run, soe, doe})
		`CHK("nofall", 0, nf)
		csn = 0;
		repeat (300) @(negedge clk);
		`CHK("shift", 8, nf)
		csn = 1;
		repeat (8) @(negedge clk);
		`CHK("abort", 5'b10000, {ab, run, irq, soe, doe})
		@(negedge clk) acn = 0;
		@(negedge clk) acn = 1;
		`CHK("abort_flag_clear", 1'b0, ab)
		se = 0;
		ie = 1;
		pulse(1);
		repeat (300) @(negedge clk);
		pulse(0);
		@(negedge clk) `CHK("stop", 2'b00, {run, done})
		give_verdict;
	end
	initial begin
		#400000;
		n_fail = n_fail + 1;
		give_verdict;
	end
endmodule // testbench
